// *** src/spiee_core.sv ***
// Serial EEPROM command logic: array, identification page and lock
`timescale 1ns/1ps
module spiee_core import spiee_pkg::*; #(
   parameter int AW = ARRAY_AW,
   parameter int unsigned TW_CYCLES = TW_US * CLK_MHZ,
   parameter logic [7:0] OPC_WRITE = 8'h02,
   parameter logic [7:0] OPC_READ = 8'h03,
   parameter logic [7:0] OPC_WRDI = 8'h04,
   parameter logic [7:0] OPC_WRITE_ENABLE_COMMAND = 8'h06,
   parameter logic [7:0] OPC_ID_WR = 8'h82,
   parameter logic [7:0] OPC_ID_RD = 8'h83
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic protect_size_high_bit,
   input wire logic protect_size_low_bit,
   output logic write_busy_flag,
   output logic write_enable_latch,
   output logic ident_page_locked
);
   localparam int PGB = 1 << PAGE_AW;
   localparam int PGG = PGB / 4;
   localparam int ID_BASE = 1 << (AW - 2);
   localparam int NGRP = ID_BASE + PGG;
   localparam int GW = $clog2(NGRP);
   localparam int TWW = $clog2(TW_CYCLES + 1);
   localparam logic [TWW-1:0] TW_LAST = TWW'(TW_CYCLES - 1);
   localparam logic [5:0] GRP_LAST = 6'(PGG - 1);

   function automatic logic [CHK_BITS-1:0] ecc_chk(input logic [31:0] d);
      logic [CHK_BITS-1:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p <= CW_BITS; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) c = c ^ p[CHK_BITS-1:0];
            k++;
         end
      end
      return c;
   endfunction : ecc_chk

   function automatic logic [31:0] ecc_fix(input logic [31:0] d,
                                           input logic [CHK_BITS-1:0] c);
      logic [CHK_BITS-1:0] s;
      logic [31:0] r;
      int k;
      s = c ^ ecc_chk(d);
      r = d;
      k = 0;
      for (int p = 1; p <= CW_BITS; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (p[CHK_BITS-1:0] == s) r[k] = ~r[k];
            k++;
         end
      end
      return r;
   endfunction : ecc_fix

   // Link side, clocked by the serial clock
   spiee_frame_t rec;
   logic in_frame, rd_active, rd_lock, rd_id;
   logic [AW-1:0] rd_ptr;
   logic fetch_tgl;
   logic [7:0] wptr;
   logic [PGB-1:0] pvalid;
   logic [7:0] pbuf [PGB];
   logic [7:0] out_sh;
   logic [1:0] st_s1, st_s2;
   logic [15:0] next_cnt;
   logic [23:0] next_addr;
   logic [7:0] next_byte;
   logic byte_done, hdr_done, wr_collect, rd_cmd;

   assign next_cnt = !in_frame ? 16'h0001 :
                     (rec.cnt == CNT_MAX) ? rec.cnt : rec.cnt + 16'h0001;
   assign next_addr = {rec.addr[22:0], sdi};
   assign next_byte = {rec.data[6:0], sdi};
   assign hdr_done = next_cnt == CNT_HDR;
   assign byte_done = next_cnt > CNT_HDR && next_cnt[2:0] == 3'h0;
   assign wr_collect = !st_s2[0] && (rec.cmd == OPC_WRITE ||
                       (rec.cmd == OPC_ID_WR && !rec.addr[PAGE_SEL_BIT]));
   assign rd_cmd = rec.cmd == OPC_READ || rec.cmd == OPC_ID_RD;

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) in_frame <= 1'b0;
      else in_frame <= 1'b1;
   end

   // Busy and lock levels into the link domain
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         st_s1 <= 2'h0;
         st_s2 <= 2'h0;
      end else begin
         st_s1 <= {ident_page_locked, write_busy_flag};
         st_s2 <= st_s1;
      end
   end

   // Frame record: opcode, address, last data byte, bit count
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         rec <= '0;
      end else begin
         rec.cnt <= next_cnt;
         rec.data <= {in_frame ? rec.data[6:0] : 7'h00, sdi};
         if (next_cnt == CNT_OP) rec.cmd <= next_byte;
         if (next_cnt > CNT_OP && next_cnt <= CNT_HDR)
            rec.addr <= next_addr;
      end
   end

   // Page buffer collects write data at wrapping byte positions
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         wptr <= 8'h00;
         pvalid <= '0;
      end else if (hdr_done) begin
         wptr <= next_addr[7:0];
      end else if (byte_done && wr_collect) begin
         if (next_cnt == CNT_DATA1) pvalid <= '0;
         pvalid[wptr] <= 1'b1;
         wptr <= wptr + 8'h01;
      end
   end

   always_ff @(posedge sck) begin
      if (in_frame && byte_done && wr_collect) pbuf[wptr] <= next_byte;
   end

   // Read engine: starts only when no write cycle runs
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) rd_active <= 1'b0;
      else if (in_frame && hdr_done && rd_cmd && !st_s2[0])
         rd_active <= 1'b1;
   end

   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         rd_ptr <= '0;
         rd_lock <= 1'b0;
         rd_id <= 1'b0;
         fetch_tgl <= 1'b0;
      end else if (in_frame && hdr_done) begin
         rd_ptr <= next_addr[AW-1:0];
         rd_id <= rec.cmd == OPC_ID_RD && !next_addr[PAGE_SEL_BIT];
         rd_lock <= rec.cmd == OPC_ID_RD && next_addr[PAGE_SEL_BIT];
         fetch_tgl <= ~fetch_tgl;
      end else if (rd_active && next_cnt > CNT_HDR &&
                   next_cnt[2:0] == 3'h1 && !rd_lock) begin
         rd_ptr <= rd_ptr + 1'b1;
         fetch_tgl <= ~fetch_tgl;
      end
   end

   logic [7:0] fetch_byte;

   // Output shifter, loads each new byte on the falling edge
   always_ff @(negedge sck or negedge arst_n) begin
      if (!arst_n) begin
         out_sh <= 8'h00;
      end else if (rd_active && rec.cnt >= CNT_HDR &&
                   rec.cnt[2:0] == 3'h0) begin
         out_sh <= rd_lock ? {7'h00, st_s2[1]} : fetch_byte;
      end else begin
         out_sh <= {out_sh[6:0], 1'b0};
      end
   end

   assign sdo = out_sh[7];
   assign sdo_oe = rd_active & ~cs_n;

   // Core side, clocked by clk
   logic [31:0] mem_d [NGRP];
   logic [CHK_BITS-1:0] mem_c [NGRP];
   logic [2:0] cs_sync, ft_sync;
   logic frame_end, fetch_ev;
   logic [GW-1:0] ridx;
   logic [31:0] rword;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_sync <= 3'h7;
         ft_sync <= 3'h0;
      end else begin
         cs_sync <= {cs_sync[1:0], cs_n};
         ft_sync <= {ft_sync[1:0], fetch_tgl};
      end
   end

   assign frame_end = cs_sync[1] & ~cs_sync[2];
   assign fetch_ev = ft_sync[1] ^ ft_sync[2];
   assign ridx = rd_id ? GW'(ID_BASE) + GW'(rd_ptr[7:2]) :
                 GW'(rd_ptr[AW-1:2]);
   assign rword = ecc_fix(mem_d[ridx], mem_c[ridx]);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) fetch_byte <= 8'h00;
      else if (fetch_ev) fetch_byte <= rword[8*rd_ptr[1:0] +: 8];
   end

   // Command decision at the end of a frame
   logic [1:0] bp;
   logic bnd, sel_hi, prot, start_arr, start_id, start_lock, done, tw_done;
   spiee_state_t st;
   logic is_id, is_lock;
   logic [AW-9:0] page;
   logic [5:0] grp;
   logic [TWW-1:0] tw;
   logic [31:0] old, merged, wword;
   logic [3:0] gvalid;

   assign bp = {protect_size_high_bit, protect_size_low_bit};
   assign bnd = rec.cnt >= CNT_DATA1 && rec.cnt[2:0] == 3'h0;
   assign sel_hi = rec.addr[PAGE_SEL_BIT];
   always_comb begin
      unique case (bp)
         BP_QUARTER: prot = rec.addr[AW-1 -: 2] == TOP_QUARTER;
         BP_HALF: prot = rec.addr[AW-1];
         BP_ALL: prot = 1'b1;
         default: prot = 1'b0;
      endcase
   end
   assign start_arr = frame_end && rec.cmd == OPC_WRITE &&
                      write_enable_latch && !write_busy_flag &&
                      bnd && !prot;
   assign start_id = frame_end && rec.cmd == OPC_ID_WR && !sel_hi &&
                     write_enable_latch && !write_busy_flag && bnd &&
                     !ident_page_locked;
   assign start_lock = frame_end && rec.cmd == OPC_ID_WR && sel_hi &&
                       write_enable_latch && !write_busy_flag &&
                       rec.cnt == CNT_DATA1 && bp != BP_ALL &&
                       rec.data[LOCK_DATA_BIT];
   assign tw_done = tw >= TW_LAST;
   assign done = st == ST_WAIT && tw_done;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) write_enable_latch <= 1'b0;
      else if (frame_end && rec.cmd == OPC_WRITE_ENABLE_COMMAND && rec.cnt == CNT_OP)
         write_enable_latch <= 1'b1;
      else if (done || (frame_end && rec.cmd == OPC_WRDI &&
                        rec.cnt == CNT_OP))
         write_enable_latch <= 1'b0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ident_page_locked <= 1'b0;
      else if (done && is_lock) ident_page_locked <= 1'b1;
   end

   // Self-timed write cycle
   assign gvalid = pvalid[{grp, 2'h0} +: 4];
   generate
      for (genvar j = 0; j < 4; j++) begin : g_merge
         assign merged[8*j +: 8] = gvalid[j] ?
                pbuf[{grp, 2'(j)}] : old[8*j +: 8];
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= ST_IDLE;
         write_busy_flag <= 1'b0;
         is_id <= 1'b0;
         is_lock <= 1'b0;
         page <= '0;
         grp <= 6'h00;
         tw <= '0;
         old <= 32'h0;
      end else begin
         tw <= write_busy_flag ? tw + 1'b1 : '0;
         unique case (st)
            ST_IDLE: begin
               if (start_arr || start_id || start_lock) begin
                  write_busy_flag <= 1'b1;
                  st <= start_lock ? ST_WAIT : ST_READ;
                  is_id <= start_id;
                  is_lock <= start_lock;
                  page <= rec.addr[AW-1:PAGE_AW];
                  grp <= 6'h00;
               end
            end
            ST_READ: begin
               old <= wword;
               if (|gvalid) st <= ST_ERASE;
               else if (grp == GRP_LAST) st <= ST_WAIT;
               else grp <= grp + 6'h01;
            end
            ST_ERASE: st <= ST_PROG;
            ST_PROG: begin
               grp <= grp + 6'h01;
               st <= grp == GRP_LAST ? ST_WAIT : ST_READ;
            end
            ST_WAIT: begin
               if (tw_done) begin
                  st <= ST_IDLE;
                  write_busy_flag <= 1'b0;
               end
            end
         endcase
      end
   end

   // Storage port; check bits of an all-zero group are zero
   logic [GW-1:0] widx;
   assign widx = is_id ? GW'(ID_BASE) + GW'(grp) : GW'({page, grp});

   always_ff @(posedge clk) begin
      if (st == ST_ERASE) begin
         mem_d[widx] <= 32'h0;
         mem_c[widx] <= '0;
      end else if (st == ST_PROG) begin
         mem_d[widx] <= merged;
         mem_c[widx] <= ecc_chk(merged);
      end
   end

   // Current contents of the group under rewrite
   assign wword = ecc_fix(mem_d[widx], mem_c[widx]);

   // Checks
   sequence s_erase;
      st == ST_ERASE;
   endsequence
   sequence s_prog;
      st == ST_PROG;
   endsequence

   a_erase_then_prog: assert property (@(posedge clk) disable iff (!arst_n)
      s_erase |=> s_prog)
      else $error("program step did not follow erase");
   a_busy_on_start: assert property (@(posedge clk) disable iff (!arst_n)
      (start_arr || start_id) |=> write_busy_flag ##1 write_busy_flag)
      else $error("busy not raised by write start");
   a_busy_full_time: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(write_busy_flag) |-> $past(tw) == TW_LAST)
      else $error("busy ended before the write period");
   a_wel_cleared: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(write_busy_flag) |-> !write_enable_latch)
      else $error("enable latch survived a write");
   a_write_guard: assert property (@(posedge clk) disable iff (!arst_n)
      start_arr |-> write_enable_latch && !write_busy_flag)
      else $error("write started without enable");
   a_write_bound: assert property (@(posedge clk) disable iff (!arst_n)
      start_arr |-> rec.cnt[2:0] == 3'h0 && !prot)
      else $error("write started off boundary or protected");
   a_lock_guard: assert property (@(posedge clk) disable iff (!arst_n)
      start_lock |-> bp != BP_ALL && rec.cnt == CNT_DATA1)
      else $error("lock accepted when it must be discarded");
   a_locked_id: assert property (@(posedge clk) disable iff (!arst_n)
      ident_page_locked |-> !start_id)
      else $error("ident write accepted on locked page");
   a_read_busy: assert property (@(posedge sck) disable iff (!arst_n)
      (in_frame && hdr_done && st_s2[0]) |=> !rd_active)
      else $error("read started during a write cycle");
endmodule : spiee_core

// *** include/spiee_pkg.sv ***
// Constants and types for the serial EEPROM command block
package spiee_pkg;
   localparam int OP_BITS = 8;
   localparam int ADDR_BITS = 24;
   localparam int BYTE_BITS = 8;
   localparam int PAGE_SEL_BIT = 10;
   localparam int LOCK_DATA_BIT = 1;
   localparam int ARRAY_AW = 18;
   localparam int PAGE_AW = 8;
   localparam int CHK_BITS = 6;
   localparam int CW_BITS = 38;
   localparam int TW_US = 10000;
   localparam int CLK_MHZ = 200;
   localparam logic [15:0] CNT_OP = 16'h0008;
   localparam logic [15:0] CNT_HDR = 16'h0020;
   localparam logic [15:0] CNT_DATA1 = 16'h0028;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [1:0] TOP_QUARTER = 2'h3;
   typedef struct packed {
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [7:0] data;
      logic [15:0] cnt;
   } spiee_frame_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_READ = 3'h1,
      ST_ERASE = 3'h3,
      ST_PROG = 3'h2,
      ST_WAIT = 3'h6
   } spiee_state_t;
endpackage : spiee_pkg

// *** dv/spiee_host.sv ***
// Host side serial bus controller model for the EEPROM command block
`timescale 1ns/1ps
module spiee_host (
   output logic sck,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   logic seen_oe;
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      sdi = 1'b1;
      seen_oe = 1'b0;
      #1;
      cs_n = 1'b1;
   end
   // One link clock period; data out is taken at the rising edge
   task automatic bit_x(input logic b, output logic r);
      sdi = b;
      #62.5;
      sck = 1'b1;
      r = sdo;
      seen_oe = seen_oe | sdo_oe;
      #62.5;
      sck = 1'b0;
   endtask : bit_x
   // Header, queued write bytes, extra loose bits, then read bytes
   task automatic frame(input logic [7:0] op, input logic [23:0] a,
         input int nhdr, input int nrd, input int extra);
      logic r;
      logic [7:0] b;
      logic [31:0] hdr;
      hdr = {op, a};
      rq = {};
      seen_oe = 1'b0;
      cs_n = 1'b0;
      #40;
      for (int i = 31; i >= 32 - nhdr; i--) bit_x(hdr[i], r);
      foreach (wq[k]) for (int i = 7; i >= 0; i--) bit_x(wq[k][i], r);
      for (int i = 0; i < extra; i++) bit_x(1'b1, r);
      for (int k = 0; k < nrd; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_x(~sdi, r);
            b[i] = r;
         end
         rq.push_back(b);
      end
      #20;
      cs_n = 1'b1;
      sdi = ~sdi;
      #40;
   endtask : frame
endmodule : spiee_host

// *** dv/test_serial_eeprom_array_and_id_page_access.sv ***
// Self-checking bench for the serial EEPROM command block
`timescale 1ns/1ps
module test_serial_eeprom_array_and_id_page_access;
   localparam int TW = 3000;
   logic clk = 1'b0;
   logic arst_n = 1'b1;
   logic bp_hi = 1'b0;
   logic bp_lo = 1'b0;
   logic sck;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic busy;
   logic latch;
   logic locked;
   int mismatches = 0;
   int checked = 0;
   always #2.5 clk = ~clk;
   spiee_core #(.TW_CYCLES(TW)) dut (
      .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .protect_size_high_bit(bp_hi),
      .protect_size_low_bit(bp_lo), .write_busy_flag(busy),
      .write_enable_latch(latch), .ident_page_locked(locked)
   );
   spiee_host h (
      .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("mismatches %0d, checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic idle();
      int n;
      n = 0;
      while (busy === 1'b1 && n < TW + 40) begin
         @(negedge clk);
         n++;
      end
      chk({7'h0, busy}, 8'h00);
   endtask : idle
   task automatic write_enable_command();
      h.wq = {};
      h.frame(8'h06, 24'h0, 8, 0, 0);
      repeat (8) @(negedge clk);
      chk({7'h0, latch}, 8'h01);
   endtask : write_enable_command
   task automatic wr(input logic [7:0] op, input logic [23:0] a,
         input int extra, input logic ok);
      h.frame(op, a, 32, 0, extra);
      repeat (8) @(negedge clk);
      chk({7'h0, busy}, {7'h0, ok});
      if (ok) begin
         repeat (TW - 20) @(negedge clk);
         chk({7'h0, busy}, 8'h01);
         idle();
         if (op == 8'h02) chk({7'h0, latch}, 8'h00);
      end
   endtask : wr
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n,
         input logic [31:0] e);
      h.wq = {};
      h.frame(op, a, 32, n, 0);
      chk({7'h0, h.seen_oe}, 8'h01);
      chk({7'h0, sdo_oe}, 8'h00);
      for (int k = 0; k < n; k++) chk(h.rq[k], e[31 - 8 * k -: 8]);
   endtask : rd
   task automatic set_bp(input logic [1:0] v);
      @(negedge clk);
      {bp_hi, bp_lo} = v;
      repeat (4) @(negedge clk);
   endtask : set_bp
   initial begin
      #450000;
      mismatches++;
      test_done();
   end
   initial begin
      #1;
      arst_n = 1'b0;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({5'h0, busy, latch, locked}, 8'h00);
      h.wq = '{8'h11};
      wr(8'h02, 24'h000010, 0, 1'b0);
      write_enable_command();
      h.wq = '{8'h01, 8'h02, 8'hA5, 8'h3C, 8'hC3, 8'h04, 8'h05, 8'h06};
      wr(8'h02, 24'h0000FC, 0, 1'b1);
      rd(8'h03, 24'h0000FC, 4, 32'h0102A53C);
      rd(8'h03, 24'h000000, 1, 32'hC3000000);
      write_enable_command();
      h.wq = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
      wr(8'h02, 24'h03FFFC, 0, 1'b1);
      rd(8'h03, 24'h03FFFE, 4, 32'h3344C304);
      rd(8'h03, 24'h03FF00, 1, 32'h55000000);
      write_enable_command();
      h.wq = '{8'h0F};
      wr(8'h02, 24'h0000FE, 0, 1'b1);
      rd(8'h03, 24'h0000FC, 4, 32'h01020F3C);
      write_enable_command();
      h.wq = '{8'h77};
      wr(8'h02, 24'h0000FE, 3, 1'b0);
      set_bp(2'h1);
      wr(8'h02, 24'h03FF00, 0, 1'b0);
      set_bp(2'h0);
      h.frame(8'h02, 24'h0000FF, 32, 0, 0);
      h.wq = {};
      h.frame(8'h03, 24'h0000FF, 32, 1, 0);
      chk({7'h0, h.seen_oe}, 8'h00);
      h.frame(8'h83, 24'h000000, 32, 1, 0);
      chk({7'h0, h.seen_oe}, 8'h00);
      idle();
      rd(8'h03, 24'h0000FC, 4, 32'h01020F77);
      write_enable_command();
      h.wq = '{8'h11, 8'h22, 8'h33, 8'h44};
      wr(8'h82, 24'h000010, 0, 1'b1);
      rd(8'h83, 24'hF00011, 2, 32'h22330000);
      rd(8'h83, 24'h000400, 2, 32'h00000000);
      h.wq = '{8'h02};
      wr(8'h82, 24'h000400, 0, 1'b0);
      write_enable_command();
      set_bp(2'h3);
      h.wq = '{8'hFE};
      wr(8'h82, 24'h000400, 0, 1'b0);
      set_bp(2'h0);
      wr(8'h82, 24'h000400, 1, 1'b0);
      wr(8'h82, 24'h000400, 0, 1'b1);
      chk({7'h0, locked}, 8'h01);
      rd(8'h83, 24'h000400, 2, 32'h01010000);
      write_enable_command();
      h.wq = '{8'h99};
      wr(8'h82, 24'h000012, 0, 1'b0);
      rd(8'h83, 24'h000010, 4, 32'h11223344);
      test_done();
   end
endmodule : test_serial_eeprom_array_and_id_page_access
